// *** hw/jlsc_regs.svh ***
/*
 * constants for the link start-up sync control block: sync source codes,
 * filter length, state codes.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef JLSC_REGS_SVH
`define JLSC_REGS_SVH
`define JLSC_SEL_SE      2'h0
`define JLSC_SEL_TIMESTAMP_PAIR   2'h1
`define JLSC_SEL_ALT     2'h2
`define JLSC_FILT_LEN    4
`define JLSC_ST_IDLE     4'h1
`define JLSC_ST_CGS      4'h2
`define JLSC_ST_ILAS     4'h4
`define JLSC_ST_DATA     4'h8
`endif

// *** hw/jlsc_pkg.sv ***
/*
 * types of the link start-up sync control block.
 * assumes the constants header sits in the include path.
 */
`default_nettype none
`include "jlsc_regs.svh"
package jlsc_pkg;
  typedef enum logic [3:0] {
    JLSC_IDLE = `JLSC_ST_IDLE,
    JLSC_CGS  = `JLSC_ST_CGS,
    JLSC_ILAS = `JLSC_ST_ILAS,
    JLSC_DATA = `JLSC_ST_DATA
  } jlsc_state_t;
  typedef struct packed {
    logic       enc_64b66b;
    logic [1:0] sync_sel;
    logic       sysref_receiver_enable;
    logic       timestamp_receiver_enable;
  } jlsc_cfg_t;
  typedef struct packed {
    logic cgs;
    logic ilas;
    logic data;
  } jlsc_lane_t;
endpackage
`default_nettype wire

// *** hw/jlsc_sync_ctrl.sv ***
/*
 * link start-up control: picks the sync request source, synchronises and
 * filters it, and steps lanes through code group sync, lane alignment and data, or straight to data with 64b66b.
 * assumes all pins already sampled in the clk domain, sync sources active low.
 */
`default_nettype none
`include "jlsc_regs.svh"
module jlsc_sync_ctrl #(
  parameter int FILT_LEN = `JLSC_FILT_LEN
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // configuration
  input  wire jlsc_pkg::jlsc_cfg_t cfg,
  // sync sources, active low
  input  wire logic                single_ended_sync_pin_n,
  input  wire logic                alternate_sync_pin_n,
  input  wire logic                timestamp_pair_n,
  // sysref
  input  wire logic                sysref,
  // lane phase, receiver power control and sysref edge
  output var  jlsc_pkg::jlsc_lane_t lane,
  output var  logic                sysref_rx_pd,
  output var  logic                timestamp_pair_rx_pd,
  output var  logic                sysref_edge
);
  import jlsc_pkg::*;

  // ****************************************
  // source select and synchroniser
  // ****************************************
  logic                sel_raw;
  logic [1:0]          sync_reg;
  logic [1:0]          sync_next;
  logic [FILT_LEN-1:0] hist_reg;
  logic [FILT_LEN-1:0] hist_next;
  logic                filt_reg;
  logic                filt_next;
  logic [2:0]          sref_reg;
  logic [2:0]          sref_next;

  always_comb begin
    case (cfg.sync_sel)
      `JLSC_SEL_SE:    sel_raw = single_ended_sync_pin_n;
      `JLSC_SEL_TIMESTAMP_PAIR: sel_raw = timestamp_pair_n;
      `JLSC_SEL_ALT:   sel_raw = alternate_sync_pin_n;
      default:         sel_raw = 1'b1;
    endcase
  end

  // filter only changes level after FILT_LEN equal samples, glitches are dropped
  always_comb begin
    sync_next = {sync_reg[0], sel_raw};
    hist_next = {hist_reg[FILT_LEN-2:0], sync_reg[1]};
    filt_next = filt_reg;
    if (&hist_reg) begin
      filt_next = 1'b1;
    end else if (~|hist_reg) begin
      filt_next = 1'b0;
    end
    // third sysref stage feeds only the edge tap, so the first flop stays private
    sref_next = {sref_reg[1:0], sysref & cfg.sysref_receiver_enable};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_reg <= 2'h3;
      hist_reg <= '1;
      filt_reg <= 1'b1;
      sref_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
      hist_reg <= hist_next;
      filt_reg <= filt_next;
      sref_reg <= sref_next;
    end
  end

  // ****************************************
  // link phase state machine
  // ****************************************
  jlsc_state_t state_reg;
  jlsc_state_t state_next;
  jlsc_lane_t  lane_next;
  logic        sysref_rx_pd_next;
  logic        timestamp_pair_rx_pd_next;
  logic        sysref_edge_next;

  // one decode shared by the lane register and the checks
  function automatic jlsc_lane_t lane_of(input jlsc_state_t s);
    jlsc_lane_t l;
    l.cgs  = (s == JLSC_CGS);
    l.ilas = (s == JLSC_ILAS);
    l.data = (s == JLSC_DATA);
    return l;
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      JLSC_IDLE: begin
        if (cfg.enc_64b66b) begin
          state_next = JLSC_DATA;
        end else if (!filt_reg) begin
          state_next = JLSC_CGS;
        end
      end
      JLSC_CGS: begin
        if (cfg.enc_64b66b) begin
          state_next = JLSC_DATA;
        end else if (filt_reg) begin
          state_next = JLSC_ILAS;
        end
      end
      JLSC_ILAS: begin
        // alignment ends on the sysref-timed multiframe boundary
        if (cfg.enc_64b66b || sref_reg[1]) begin
          state_next = JLSC_DATA;
        end else if (!filt_reg) begin
          state_next = JLSC_CGS;
        end
      end
      JLSC_DATA: begin
        if (!cfg.enc_64b66b && !filt_reg) begin
          state_next = JLSC_CGS;
        end
      end
      default: state_next = JLSC_IDLE;
    endcase
    lane_next = lane_of(state_next);
    sysref_rx_pd_next = ~cfg.sysref_receiver_enable;
    timestamp_pair_rx_pd_next  = ~cfg.timestamp_receiver_enable;
    sysref_edge_next  = sref_reg[1] & ~sref_reg[2];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= JLSC_IDLE;
      lane         <= '0;
      sysref_rx_pd <= 1'b1;
      timestamp_pair_rx_pd  <= 1'b1;
      sysref_edge  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      lane         <= lane_next;
      sysref_rx_pd <= sysref_rx_pd_next;
      timestamp_pair_rx_pd  <= timestamp_pair_rx_pd_next;
      sysref_edge  <= sysref_edge_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // lane is registered from state_next, so it always mirrors state_reg
  a_skip_in_66b: assert property (@(posedge clk) disable iff (srst)
    cfg.enc_64b66b && !lane.data |=> ##[0:1] lane.data)
    else $error("64b66b mode did not reach data");
  a_cgs_on_low: assert property (@(posedge clk) disable iff (srst)
    !cfg.enc_64b66b && !filt_reg && lane.data |=> lane.cgs)
    else $error("sync low did not start cgs");
  a_ilas_on_high: assert property (@(posedge clk) disable iff (srst)
    !cfg.enc_64b66b && lane.cgs && filt_reg |=> lane.ilas)
    else $error("sync high did not start ilas");
  a_filter_hold: assert property (@(posedge clk) disable iff (srst)
    $fell(filt_reg) |-> $past(hist_reg) == '0)
    else $error("filter fell without full agreement");
  a_se_select: assert property (@(posedge clk) disable iff (srst)
    cfg.sync_sel == `JLSC_SEL_SE |=> sync_reg[0] == $past(single_ended_sync_pin_n))
    else $error("single-ended pin not sampled");
  a_timestamp_pair_select: assert property (@(posedge clk) disable iff (srst)
    cfg.sync_sel == `JLSC_SEL_TIMESTAMP_PAIR |=> sync_reg[0] == $past(timestamp_pair_n))
    else $error("timestamp pair not sampled");
  a_alt_select: assert property (@(posedge clk) disable iff (srst)
    cfg.sync_sel == `JLSC_SEL_ALT |=> sync_reg[0] == $past(alternate_sync_pin_n))
    else $error("alternate pin not sampled");
  a_none_high: assert property (@(posedge clk) disable iff (srst)
    cfg.sync_sel == 2'h3 |=> sync_reg[0])
    else $error("unused source code did not read idle");
  a_filter_rise: assert property (@(posedge clk) disable iff (srst)
    $rose(filt_reg) |-> $past(hist_reg) == '1)
    else $error("filter rose without full agreement");
  a_sysref_pd: assert property (@(posedge clk) disable iff (srst)
    !cfg.sysref_receiver_enable |=> sysref_rx_pd)
    else $error("sysref receiver not powered down");
  a_timestamp_pair_pd: assert property (@(posedge clk) disable iff (srst)
    !cfg.timestamp_receiver_enable |=> timestamp_pair_rx_pd)
    else $error("timestamp receiver not powered down");
  a_timestamp_pair_on: assert property (@(posedge clk) disable iff (srst)
    cfg.timestamp_receiver_enable |=> !timestamp_pair_rx_pd)
    else $error("timestamp receiver wrongly powered down");
  a_ilas_exit: assert property (@(posedge clk) disable iff (srst)
    !cfg.enc_64b66b && lane.ilas && sref_reg[1] |=> lane.data)
    else $error("sysref did not end ilas");
  a_ilas_drop: assert property (@(posedge clk) disable iff (srst)
    !cfg.enc_64b66b && lane.ilas && !sref_reg[1] && !filt_reg |=> lane.cgs)
    else $error("sync low in ilas did not restart cgs");
  a_idle_hold: assert property (@(posedge clk) disable iff (srst)
    !cfg.enc_64b66b && lane == '0 && filt_reg |=> lane == '0)
    else $error("link left idle without a sync request");
  a_data_hold: assert property (@(posedge clk) disable iff (srst)
    !cfg.enc_64b66b && lane.data && filt_reg |=> lane.data)
    else $error("data phase left while sync high");
  a_lane_onehot: assert property (@(posedge clk) disable iff (srst)
    $onehot0(lane))
    else $error("more than one lane phase active");
  a_lane_state: assert property (@(posedge clk) disable iff (srst)
    lane == lane_of(state_reg))
    else $error("lane phase does not match state");
  a_edge_pulse: assert property (@(posedge clk) disable iff (srst)
    sysref_edge |=> !sysref_edge)
    else $error("sysref edge longer than one cycle");
  a_edge_cause: assert property (@(posedge clk) disable iff (srst)
    sysref_edge |-> $past(sysref, 3))
    else $error("sysref edge without sysref high");
  a_edge_gated: assert property (@(posedge clk) disable iff (srst)
    sysref_edge |-> $past(cfg.sysref_receiver_enable, 3))
    else $error("sysref edge while receiver powered down");
endmodule // jlsc_sync_ctrl
`default_nettype wire

// *** dv/jlsc_rx_model.sv ***
/*
 * far-end receiver model: drives the active-low sync request of the link.
 * assumes go lasts one cycle and hold gives the length of the low phase.
 */
`default_nettype none
module jlsc_rx_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // request
  input  wire logic       go,
  input  wire logic [7:0] hold,
  // sync, active low
  output var  logic       sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // low phase counter
  // ****
  logic [7:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (srst) cnt_reg <= 8'h00;
    else if (go) cnt_reg <= hold;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  // released high once the low phase is over
  always_comb sync_n = (cnt_reg == 8'h00);
endmodule // jlsc_rx_model
`default_nettype wire

// *** dv/tb_jlsc_sync_ctrl.sv ***
/*
 * self-checking bench for the link start-up sync control.
 * assumes the default filter length and lane as {cgs, ilas, data}.
 */
`default_nettype none
module tb_jlsc_sync_ctrl;
  import jlsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // stimulus and partner
  // ****
  logic clk = 1'b0, srst = 1'b1, sysref = 1'b0, go = 1'b0, sync_n;
  logic [7:0] hold = 8'h00;
  logic [31:0] rnd = 32'hA038F30D;
  jlsc_cfg_t cfg = '{1'b0, 2'h0, 1'b1, 1'b1};
  jlsc_lane_t lane, last, exp_q[$];
  logic sysref_rx_pd, timestamp_pair_rx_pd, sysref_edge;
  int failures = 0, n_compared = 0;
  int edges = 0, exp_edges = 0;
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  always @(posedge clk) begin
    #1;
    rnd = lfsr(rnd);
  end
  jlsc_rx_model rx (.clk(clk), .srst(srst), .go(go), .hold(hold), .sync_n(sync_n));
  // unselected sources toggle at random; the single-ended pin is tied low when unused
  jlsc_sync_ctrl DUT (.clk(clk), .srst(srst), .cfg(cfg),
    .single_ended_sync_pin_n(cfg.sync_sel == 2'h0 && !cfg.enc_64b66b ? sync_n : 1'b0),
    .alternate_sync_pin_n(cfg.sync_sel == 2'h2 ? sync_n : rnd[1]),
    .timestamp_pair_n(cfg.sync_sel == 2'h1 ? sync_n : rnd[2]),
    .sysref(sysref), .lane(lane), .sysref_rx_pd(sysref_rx_pd),
    .timestamp_pair_rx_pd(timestamp_pair_rx_pd), .sysref_edge(sysref_edge));
  // ****
  // tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pd(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: power-down got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_edge(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: sysref edges got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [7:0] h);
    go = 1'b1;
    hold = h;
    cyc(1);
    go = 1'b0;
  endtask
  task automatic wait_lane(input logic [2:0] v);
    int n;
    n = 0;
    while (lane !== v && n < 40) begin
      cyc(1);
      n++;
    end
    if (n == 40) chk(lane, v);
  endtask
  task automatic restart(input logic [1:0] sel, input logic enc);
    srst = 1'b1;
    cfg.sync_sel = sel;
    cfg.enc_64b66b = enc;
    cyc(2);
    srst = 1'b0;
  endtask
  task automatic link(input logic [1:0] sel);
    restart(sel, 1'b0);
    pulse(8'h02);
    cyc(20);
    // second round starts from the data phase, so data -> cgs is exercised too
    for (int r = 0; r < 2; r++) begin
      exp_q.push_back(3'b100);
      pulse(8'h0C + {4'h0, rnd[3:0]});
      wait_lane(3'b100);
      exp_q.push_back(3'b010);
      wait_lane(3'b010);
      exp_q.push_back(3'b001);
      sysref = 1'b1;
      exp_edges++;
      wait_lane(3'b001);
      sysref = 1'b0;
      cyc(2);
      chk_edge(edges, exp_edges);
    end
    $display("test link %0d done", sel);
  endtask
  task automatic give_verdict();
    if (exp_q.size() != 0) failures++;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****
  // checking and sequence
  // ****
  // outputs looked at mid-cycle, where they are settled
  always @(negedge clk) begin
    if (lane !== last) begin
      if (!srst) chk(lane, exp_q.size() > 0 ? exp_q.pop_front() : last);
      last = lane;
    end
    if (!srst && sysref_edge === 1'b1) edges++;
  end
  initial begin
    #50000;
    failures++;
    give_verdict();
  end
  initial begin
    cyc(10);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cfg.sysref_receiver_enable = i[0];
      cfg.timestamp_receiver_enable = i[1];
      sysref = 1'b1;
      if (i[0]) exp_edges++;
      cyc(2);
      chk_pd(sysref_rx_pd, ~i[0]);
      chk_pd(timestamp_pair_rx_pd, ~i[1]);
      sysref = 1'b0;
      cyc(2);
    end
    chk_edge(edges, exp_edges);
    $display("test power_down done");
    link(2'h0);
    link(2'h1);
    link(2'h2);
    restart(2'h2, 1'b1);
    exp_q.push_back(3'b001);
    wait_lane(3'b001);
    pulse(8'h10);
    cyc(30);
    $display("test wide_mode done");
    restart(2'h3, 1'b0);
    pulse(8'h10);
    cyc(30);
    $display("test no_source done");
    give_verdict();
  end
endmodule // tb_jlsc_sync_ctrl
`default_nettype wire
